/* include/lbus_map.svh */
// Constants of the local bus port: decode bases, register offsets, fields, timing
// Contract
// - Host qualifies each data byte with low enable
// - Address lines 31:2 are inputs only
// - Register decode uses address lines 15:2 only
// - Status low means I/O, high means memory
// - Write/read status low read, high write
// - Host strobe low marks valid address, start
// - All signalling timed by the local clock
// - Read data held while ready return withheld
// - Device claims its resources with low output
// - Device ends each cycle with open-collector ready
// - High reset input holds device in reset
// - Interrupt output low while condition pending; the device drives it low only while a pending bit is also set in IO_INT_MASK
`ifndef LBUS_MAP_SVH
`define LBUS_MAP_SVH
// Memory window: 16 words at a[31:6] == base
`define MEM_BASE_HI  26'h000_4000
`define MEM_WORDS    16
// I/O window: 4 registers at a[15:4] == base
`define IO_BASE_HI   12'h03D_0
// I/O register word offsets, a[3:2]
`define IO_SCRATCH   2'h0
`define IO_INT_STAT  2'h1
`define IO_INT_MASK  2'h2
`define IO_INT_SET   2'h3
// Pending bits: 0 set by software, 1 set by memory write
`define INT_SW_BIT   0
`define INT_MEM_BIT  1
`define INT_BITS     2
// Host gives up a cycle after this many clocks
`define HOST_TMO_CYC 8'h10
`endif

/* include/lbus_pkg.sv */
// Types shared by both ends of the local bus port
`include "lbus_map.svh"
package lbus_pkg;
  typedef enum logic [1:0] {
    DEV_IDLE  = 2'b00,
    DEV_CLAIM = 2'b01,
    DEV_READY = 2'b11,
    DEV_HOLD  = 2'b10
  } dev_state_e;
  typedef enum logic [1:0] {
    HST_IDLE   = 2'b00,
    HST_STROBE = 2'b01,
    HST_WAIT   = 2'b11,
    HST_RETURN = 2'b10
  } host_state_e;
  typedef logic [31:0] word_t;
endpackage

/* include/lbus_if.sv */
// Local bus wires between the host and the device, with wire resolution
interface lbus_if;
  import lbus_pkg::*;
  logic [31:2] addr;
  logic        lane3_enable_n;
  logic        lane2_enable_n;
  logic        lane1_enable_n;
  logic        lane0_enable_n;
  logic        mem_or_io_select;
  logic        write_not_read;
  logic        addr_status_strobe_n;
  logic        ready_return_n;
  logic        bus_reset;
  word_t       host_data;
  logic        host_data_oe;
  word_t       dev_data;
  logic        dev_data_oe;
  logic        claim_out_n;
  logic        claim_oe;
  logic        ready_out_n;
  logic        ready_oe;
  logic        int_out_n;
  logic        int_oe;
  // Resolved wires; pull-ups make undriven lines read high
  word_t       data;
  logic        claim_n;
  logic        ready_n;
  logic        int_n;
  assign data    = dev_data_oe ? dev_data : (host_data_oe ? host_data : 32'hFFFF_FFFF);
  assign claim_n = claim_oe ? claim_out_n : 1'b1;
  assign ready_n = ready_oe ? ready_out_n : 1'b1;
  assign int_n   = int_oe ? int_out_n : 1'b1;
  modport dev (
    input  addr, lane3_enable_n, lane2_enable_n, lane1_enable_n, lane0_enable_n,
    input  mem_or_io_select, write_not_read, addr_status_strobe_n, ready_return_n,
    input  bus_reset, data,
    output dev_data, dev_data_oe, claim_out_n, claim_oe, ready_out_n, ready_oe,
    output int_out_n, int_oe
  );
  modport host (
    output addr, lane3_enable_n, lane2_enable_n, lane1_enable_n, lane0_enable_n,
    output mem_or_io_select, write_not_read, addr_status_strobe_n, ready_return_n,
    output bus_reset, host_data, host_data_oe,
    input  data, claim_n, ready_n, int_n
  );
endinterface

/* core/lbus_device.sv */
// Device end of the local bus port: decode, claim, ready, memory, registers, interrupt
`include "lbus_map.svh"
module lbus_device
  import lbus_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  lbus_if.dev              bus,
  output logic [1:0]       o_int_pending,
  output logic             o_in_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    dev_state_e                       st;
    logic [31:2]                      addr;
    logic [3:0]                       be_n;
    logic                             is_mem;
    logic                             wr;
    word_t                            rdata;
    word_t                            scratch;
    logic [`INT_BITS-1:0]             pend;
    logic [`INT_BITS-1:0]             mask;
    logic                             held;
    logic [`MEM_WORDS-1:0][31:0]      mem;
  } dev_s;

  dev_s r;
  dev_s next_r;

  // Merge only the enabled lanes of a new word into an old one
  function automatic word_t merge(input word_t old_w, input word_t new_w,
                                  input logic [3:0] be_n);
    word_t res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (!be_n[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the strobed address
  logic [3:0]  lanes_n;
  logic        mem_hit;
  logic        io_hit;
  logic [3:0]  mem_idx;
  logic [1:0]  io_idx;

  // Lanes gathered from the four enables
  assign lanes_n = {bus.lane3_enable_n, bus.lane2_enable_n,
                    bus.lane1_enable_n, bus.lane0_enable_n};
  // Address is only ever read here, never driven
  assign mem_hit = bus.mem_or_io_select && (bus.addr[31:6] == `MEM_BASE_HI);
  // Upper address ignored for I/O, so aliases repeat every 64 KiB
  assign io_hit  = !bus.mem_or_io_select && (bus.addr[15:4] == `IO_BASE_HI);
  assign mem_idx = r.addr[5:2];
  assign io_idx  = r.addr[3:2];

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  logic [`INT_BITS-1:0] int_set;
  logic [`INT_BITS-1:0] int_clr;

  always_comb begin
    next_r  = r;
    int_set = '0;
    int_clr = '0;
    next_r.held = 1'b0;
    case (r.st)
      DEV_IDLE: begin
        // Strobe low means address, lanes and status are valid
        if (!bus.addr_status_strobe_n) begin
          next_r.addr   = bus.addr;
          next_r.be_n   = lanes_n;
          next_r.is_mem = bus.mem_or_io_select;
          next_r.wr     = bus.write_not_read;
          if (mem_hit || io_hit) begin
            next_r.st = DEV_CLAIM;
          end
        end
      end
      DEV_CLAIM: begin
        next_r.st = DEV_READY;
        if (r.wr) begin
          // Disabled lanes keep their old bytes
          if (r.is_mem) begin
            next_r.mem[mem_idx] = merge(r.mem[mem_idx], bus.data, r.be_n);
            int_set[`INT_MEM_BIT] = 1'b1;
          end else begin
            case (io_idx)
              `IO_SCRATCH:  next_r.scratch = merge(r.scratch, bus.data, r.be_n);
              `IO_INT_STAT: begin
                if (!r.be_n[0]) begin
                  int_clr = bus.data[`INT_BITS-1:0];
                end
              end
              `IO_INT_MASK: begin
                if (!r.be_n[0]) begin
                  next_r.mask = bus.data[`INT_BITS-1:0];
                end
              end
              `IO_INT_SET: begin
                if (!r.be_n[0]) begin
                  int_set[`INT_SW_BIT] = bus.data[`INT_SW_BIT];
                end
              end
              default: ;
            endcase
          end
        end else begin
          // Read data is latched here so it is valid with ready
          if (r.is_mem) begin
            next_r.rdata = r.mem[mem_idx];
          end else begin
            case (io_idx)
              `IO_SCRATCH:  next_r.rdata = r.scratch;
              `IO_INT_STAT: next_r.rdata = {30'h0000_0000, r.pend};
              `IO_INT_MASK: next_r.rdata = {30'h0000_0000, r.mask};
              default:      next_r.rdata = 32'h0000_0000;
            endcase
          end
        end
      end
      DEV_READY: begin
        // Writes end at once; reads wait for the return
        if (r.wr || !bus.ready_return_n) begin
          next_r.st = DEV_IDLE;
        end else begin
          next_r.st = DEV_HOLD;
        end
      end
      DEV_HOLD: begin
        if (!bus.ready_return_n) begin
          next_r.st = DEV_IDLE;
        end
      end
      default: next_r.st = DEV_IDLE;
    endcase
    // Set wins over a clear in the same cycle
    next_r.pend = (r.pend & ~int_clr) | int_set;
    // Bus reset forces the whole reset state, memory included
    if (bus.bus_reset) begin
      next_r      = '0;
      next_r.held = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus drivers
  // Claim held for the whole cycle, released when idle
  assign bus.claim_out_n = 1'b0;
  assign bus.claim_oe    = (r.st != DEV_IDLE);
  // Open collector: only ever pulls low
  assign bus.ready_out_n = 1'b0;
  assign bus.ready_oe    = (r.st == DEV_READY);
  assign bus.int_out_n   = 1'b0;
  assign bus.int_oe      = |(r.pend & r.mask);
  // Read data driven from ready until the return arrives
  assign bus.dev_data    = r.rdata;
  assign bus.dev_data_oe = !r.wr && ((r.st == DEV_READY) || (r.st == DEV_HOLD));
  assign o_int_pending   = r.pend;
  assign o_in_reset      = r.held;

endmodule

/* core/lbus_host.sv */
// Host end of the local bus port: runs one cycle per user request
`include "lbus_map.svh"
module lbus_host
  import lbus_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_bus_reset,
  input  wire logic        i_req,
  input  wire logic        i_is_mem,
  input  wire logic        i_write,
  input  wire logic [31:2] i_addr,
  input  wire logic [3:0]  i_lanes_n,
  input  wire logic [31:0] i_wdata,
  lbus_if.host             bus,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_timeout,
  output logic [31:0]      o_rdata,
  output logic             o_int
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    host_state_e st;
    logic [31:2] addr;
    logic [3:0]  lanes_n;
    logic        is_mem;
    logic        wr;
    logic        strobe_n;
    logic        return_n;
    word_t       wdata;
    logic        data_oe;
    word_t       rdata;
    logic        done;
    logic        timeout;
    logic [7:0]  cnt;
    logic        rst_out;
  } host_s;

  host_s r;
  host_s next_r;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_r         = r;
    next_r.done    = 1'b0;
    next_r.rst_out = i_bus_reset;
    case (r.st)
      HST_IDLE: begin
        next_r.return_n = 1'b1;
        // Requests while busy are not seen; o_busy shows it
        if (i_req) begin
          next_r.addr     = i_addr;
          next_r.lanes_n  = i_lanes_n;
          next_r.is_mem   = i_is_mem;
          next_r.wr       = i_write;
          next_r.wdata    = i_wdata;
          next_r.data_oe  = i_write;
          next_r.strobe_n = 1'b0;
          next_r.timeout  = 1'b0;
          next_r.cnt      = 8'h00;
          next_r.st       = HST_STROBE;
        end
      end
      HST_STROBE: begin
        // Strobe is a single clock
        next_r.strobe_n = 1'b1;
        next_r.st       = HST_WAIT;
      end
      HST_WAIT: begin
        next_r.cnt = r.cnt + 8'h01;
        if (!bus.ready_n) begin
          next_r.data_oe = 1'b0;
          if (r.wr) begin
            next_r.done = 1'b1;
            next_r.st   = HST_IDLE;
          end else begin
            next_r.rdata    = bus.data;
            next_r.return_n = 1'b0;
            next_r.st       = HST_RETURN;
          end
        end else if (r.cnt == `HOST_TMO_CYC) begin
          // No one answered; give up rather than hang
          next_r.data_oe = 1'b0;
          next_r.timeout = 1'b1;
          next_r.done    = 1'b1;
          next_r.st      = HST_IDLE;
        end
      end
      HST_RETURN: begin
        next_r.return_n = 1'b1;
        next_r.done     = 1'b1;
        next_r.st       = HST_IDLE;
      end
      default: next_r.st = HST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r          <= '0;
      r.strobe_n <= 1'b1;
      r.return_n <= 1'b1;
      r.lanes_n  <= 4'hF;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus and user outputs, all from flops except o_int, which follows the bus interrupt wire
  assign bus.addr                 = r.addr;
  assign bus.lane3_enable_n       = r.lanes_n[3];
  assign bus.lane2_enable_n       = r.lanes_n[2];
  assign bus.lane1_enable_n       = r.lanes_n[1];
  assign bus.lane0_enable_n       = r.lanes_n[0];
  assign bus.mem_or_io_select     = r.is_mem;
  assign bus.write_not_read       = r.wr;
  assign bus.addr_status_strobe_n = r.strobe_n;
  assign bus.ready_return_n       = r.return_n;
  assign bus.bus_reset            = r.rst_out;
  assign bus.host_data            = r.wdata;
  assign bus.host_data_oe         = r.data_oe;
  assign o_busy                   = (r.st != HST_IDLE);
  assign o_done                   = r.done;
  assign o_timeout                = r.timeout;
  assign o_rdata                  = r.rdata;
  assign o_int                    = !bus.int_n;

endmodule

/* bench/lbus_sva.sv */
// Concurrent checks on the local bus wires between the host and device ends
`include "lbus_map.svh"
module lbus_sva
  import lbus_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic [31:2] addr,
  input wire logic        mem_or_io_select,
  input wire logic        write_not_read,
  input wire logic        addr_status_strobe_n,
  input wire logic        ready_return_n,
  input wire logic        bus_reset,
  input wire word_t       dev_data,
  input wire logic        dev_data_oe,
  input wire logic        claim_out_n,
  input wire logic        claim_oe,
  input wire logic        ready_oe,
  input wire logic        int_out_n,
  input wire logic        int_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  // Strobe decode; a bus reset drops the cycle, so it masks the strobe
  logic strobe;
  logic mem_hit;
  logic io_hit;
  assign strobe  = !addr_status_strobe_n && !bus_reset;
  assign mem_hit = mem_or_io_select && (addr[31:6] == `MEM_BASE_HI);
  assign io_hit  = !mem_or_io_select && (addr[15:4] == `IO_BASE_HI);
  // Claim one cycle after strobe, ready one cycle later and only once
  sequence s_answer;
    ##1 claim_oe ##1 (claim_oe && ready_oe) ##1 !ready_oe;
  endsequence
  sequence s_rd_hit;
    strobe && (mem_hit || io_hit) && !write_not_read;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_mem_claim: assert property (strobe && mem_hit |-> s_answer)
    else $error("memory hit not claimed and readied in time");
  a_io_decode: assert property (strobe && io_hit |-> s_answer)
    else $error("register hit not claimed and readied in time");
  a_miss_quiet: assert property (strobe && !mem_hit && !io_hit |=> (!claim_oe && !ready_oe) [*3])
    else $error("device answered a cycle it does not own");
  a_read_drive: assert property (s_rd_hit |-> ##2 (dev_data_oe && ready_oe))
    else $error("read data not driven with ready");
  a_write_nodrive: assert property (strobe && write_not_read |=> !dev_data_oe [*4])
    else $error("device drove data in a write cycle");
  a_read_hold: assert property (dev_data_oe && ready_return_n && !bus_reset
                                |=> dev_data_oe && $stable(dev_data))
    else $error("read data dropped before ready return");
  a_claim_level: assert property (claim_oe |-> !claim_out_n)
    else $error("claim driven high");
  a_ready_claimed: assert property (ready_oe |-> claim_oe)
    else $error("ready outside a claimed cycle");
  a_int_level: assert property (int_oe |-> !int_out_n)
    else $error("interrupt driven high");
  a_bus_reset: assert property (bus_reset |=> !claim_oe && !ready_oe && !int_oe && !dev_data_oe)
    else $error("outputs active after bus reset");
endmodule

/* bench/tb_top.sv */
// Self-checking bench joining the host and device ends of the local bus port
`include "lbus_map.svh"
module tb_top
  import lbus_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:2] MEM0 = {`MEM_BASE_HI, 4'h0};
  localparam logic [31:2] IO0  = {16'hABCD, `IO_BASE_HI, `IO_SCRATCH};
  logic        i_clk       = 1'b0;
  logic        i_rst_b     = 1'b0;
  logic        i_bus_reset = 1'b0;
  logic        i_req       = 1'b0;
  logic        i_is_mem    = 1'b0;
  logic        i_write     = 1'b0;
  logic [31:2] i_addr      = '0;
  logic [3:0]  i_lanes_n   = 4'hF;
  word_t       i_wdata     = '0;
  logic        o_busy;
  logic        o_done;
  logic        o_timeout;
  logic        o_int;
  logic        o_in_reset;
  logic [1:0]  o_int_pending;
  word_t       o_rdata;
  int          n_mismatch  = 0;
  int          n_checks    = 0;
  int          cyc         = 0;
  // Free-running 50 MHz clock
  always #10 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////////////////////
  lbus_if u_lbus_if ();
  lbus_host u_lbus_host (.i_clk (i_clk), .i_rst_b (i_rst_b), .i_bus_reset (i_bus_reset),
    .i_req (i_req), .i_is_mem (i_is_mem), .i_write (i_write), .i_addr (i_addr),
    .i_lanes_n (i_lanes_n), .i_wdata (i_wdata), .bus (u_lbus_if), .o_busy (o_busy),
    .o_done (o_done), .o_timeout (o_timeout), .o_rdata (o_rdata), .o_int (o_int));
  lbus_device u_lbus_device (.i_clk (i_clk), .i_rst_b (i_rst_b), .bus (u_lbus_if),
    .o_int_pending (o_int_pending), .o_in_reset (o_in_reset));
  lbus_sva u_lbus_sva (.i_clk (i_clk), .i_rst_b (i_rst_b), .addr (u_lbus_if.addr),
    .mem_or_io_select (u_lbus_if.mem_or_io_select), .write_not_read (u_lbus_if.write_not_read),
    .addr_status_strobe_n (u_lbus_if.addr_status_strobe_n), .bus_reset (u_lbus_if.bus_reset),
    .ready_return_n (u_lbus_if.ready_return_n), .dev_data (u_lbus_if.dev_data),
    .dev_data_oe (u_lbus_if.dev_data_oe), .claim_out_n (u_lbus_if.claim_out_n),
    .claim_oe (u_lbus_if.claim_oe), .ready_oe (u_lbus_if.ready_oe),
    .int_out_n (u_lbus_if.int_out_n), .int_oe (u_lbus_if.int_oe));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count; four-state compare so unknowns never match
  task automatic chk(input string what, input word_t exp, input word_t got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One host cycle: request held for the take edge, then bounded wait for done
  task automatic op(input logic mem, input logic wr, input logic [31:2] a,
                    input logic [3:0] ln, input word_t wd);
    @(posedge i_clk);
    i_req     <= 1'b1;
    i_is_mem  <= mem;
    i_write   <= wr;
    i_addr    <= a;
    i_lanes_n <= ln;
    i_wdata   <= wd;
    @(posedge i_clk);
    i_req <= 1'b0;
    // Request taken on this edge, so the host must show a running cycle
    #1;
    chk("busy", 32'h0000_0001, word_t'(o_busy));
    repeat (40) begin
      @(posedge i_clk);
      #1;
      if (o_done === 1'b1) break;
    end
    chk("done", 32'h0000_0001, word_t'(o_done));
    chk("idle", 32'h0000_0000, word_t'(o_busy));
  endtask
  task automatic rd(input logic mem, input logic [31:2] a, input word_t exp);
    op(mem, 1'b0, a, 4'h0, '0);
    chk("read data", exp, o_rdata);
  endtask
  // Unowned cycle: only the host's give-up ends it
  task automatic miss(input logic mem, input logic [31:2] a);
    op(mem, 1'b0, a, 4'h0, '0);
    chk("timeout", 32'h0000_0001, word_t'(o_timeout));
  endtask
  function automatic logic [31:2] reg_a(input logic [1:0] off);
    return {16'h0000, `IO_BASE_HI, off};
  endfunction
  task automatic give_verdict();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hang guard; the whole sequence needs well under a thousand cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    op(1'b1, 1'b1, MEM0, 4'h0, 32'h1111_2222);
    rd(1'b1, MEM0, 32'h1111_2222);
    op(1'b1, 1'b1, MEM0, 4'b1010, 32'hAABB_CCDD);
    rd(1'b1, MEM0, 32'h11BB_22DD);
    for (int i = 0; i < 4; i++) begin
      op(1'b1, 1'b1, MEM0 + 30'(i + 1), 4'h0, '0);
      op(1'b1, 1'b1, MEM0 + 30'(i + 1), ~(4'h1 << i), 32'hFFFF_FFFF);
      rd(1'b1, MEM0 + 30'(i + 1), 32'h0000_00FF << (8 * i));
    end
    miss(1'b1, {26'h000_8000, 4'h0});
    miss(1'b0, MEM0);
    miss(1'b1, IO0);
    op(1'b0, 1'b1, IO0, 4'h0, 32'h5A5A_C3C3);
    rd(1'b0, reg_a(`IO_SCRATCH), 32'h5A5A_C3C3);
    // Memory writes left the memory pending bit set, masked so far
    chk("pending", 32'h0000_0002, word_t'(o_int_pending));
    chk("interrupt", 32'h0000_0000, word_t'(o_int));
    op(1'b0, 1'b1, reg_a(`IO_INT_STAT), 4'hE, 32'h0000_0003);
    op(1'b0, 1'b1, reg_a(`IO_INT_SET), 4'hE, 32'h0000_0001);
    chk("pending", 32'h0000_0001, word_t'(o_int_pending));
    op(1'b0, 1'b1, reg_a(`IO_INT_MASK), 4'hE, 32'h0000_0003);
    chk("interrupt", 32'h0000_0001, word_t'(o_int));
    op(1'b1, 1'b1, MEM0, 4'h0, 32'h0000_0000);
    chk("pending", 32'h0000_0003, word_t'(o_int_pending));
    op(1'b0, 1'b1, reg_a(`IO_INT_STAT), 4'hE, 32'h0000_0003);
    chk("interrupt", 32'h0000_0000, word_t'(o_int));
    op(1'b0, 1'b1, reg_a(`IO_INT_SET), 4'hE, 32'h0000_0001);
    // Bus reset must wipe memory, registers and pending state
    @(posedge i_clk);
    i_bus_reset <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    chk("in reset", 32'h0000_0001, word_t'(o_in_reset));
    @(posedge i_clk);
    i_bus_reset <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    chk("pending", 32'h0000_0000, word_t'(o_int_pending));
    rd(1'b1, MEM0 + 30'(1), 32'h0000_0000);
    rd(1'b0, reg_a(`IO_SCRATCH), 32'h0000_0000);
    give_verdict();
  end
endmodule
